// *** include/ifc_pkg.sv ***
// Package for the ingress flow-control assist: register map, field layout, resets and carriers
package ifc_pkg;

	// Data store geometry and widths
	localparam int FREE_W = 12;
	localparam logic [11:0] FREE_TOTAL = 12'h800;
	localparam int BLADE_W = 6;
	localparam int BLADES = 64;
	localparam int QCNT_W = 16;
	localparam int PROB_W = 8;
	localparam int PROB_DEPTH = 64;
	localparam int PIDX_W = 6;
	localparam int ARR_W = 32;
	localparam int PERIOD_W = 16;
	localparam int ADR_W = 9;
	localparam int LFSR_W = 16;

	// Register byte offsets
	localparam logic [8:0] OFF_FREE_COUNT = 9'h000;
	localparam logic [8:0] OFF_GUIDED_STOP = 9'h004;
	localparam logic [8:0] OFF_USER_STOP = 9'h008;
	localparam logic [8:0] OFF_NEWF_STOP = 9'h00C;
	localparam logic [8:0] OFF_ALARM = 9'h010;
	localparam logic [8:0] OFF_USER_REL = 9'h014;
	localparam logic [8:0] OFF_NEWF_REL = 9'h018;
	localparam logic [8:0] OFF_HIGH_DROP = 9'h01C;
	localparam logic [8:0] OFF_LOW_DROP = 9'h020;
	localparam logic [8:0] OFF_EXT_SIGNAL = 9'h024;
	localparam logic [8:0] OFF_CTRL = 9'h028;
	localparam logic [8:0] OFF_PERIOD = 9'h02C;
	localparam logic [8:0] OFF_ARRIVAL = 9'h030;
	localparam logic [8:0] OFF_AVERAGE = 9'h034;
	localparam logic [8:0] OFF_INT_STATUS = 9'h038;
	localparam logic [8:0] OFF_INT_MASK = 9'h03C;
	localparam logic [8:0] OFF_QUEUE_LIMIT = 9'h040;
	localparam logic [8:0] OFF_STATE = 9'h044;
	localparam logic [8:0] OFF_LOCAL_LO = 9'h048;
	localparam logic [8:0] OFF_LOCAL_HI = 9'h04C;
	localparam logic [8:0] OFF_REM0_LO = 9'h050;
	localparam logic [8:0] OFF_REM0_HI = 9'h054;
	localparam logic [8:0] OFF_REM1_LO = 9'h058;
	localparam logic [8:0] OFF_REM1_HI = 9'h05C;
	localparam int PROB_BASE_BIT = 8;

	// Control register fields
	localparam int CTRL_USER_REL_EN = 0;
	localparam int CTRL_NEWF_REL_EN = 1;
	localparam int CTRL_K_LSB = 2;

	// Interrupt status bit positions
	localparam int INT_USER_STOP = 0;
	localparam int INT_NEWF_STOP = 1;
	localparam int INT_ALARM = 2;
	localparam int INT_W = 3;

	// Reset values
	localparam logic [11:0] RST_GUIDED_STOP = 12'h010;
	localparam logic [11:0] RST_USER_STOP = 12'h040;
	localparam logic [11:0] RST_NEWF_STOP = 12'h080;
	localparam logic [11:0] RST_ALARM = 12'h100;
	localparam logic [11:0] RST_RELEASE = 12'h000;
	localparam logic [11:0] RST_HIGH_DROP = 12'h020;
	localparam logic [11:0] RST_LOW_DROP = 12'h060;
	localparam logic [11:0] RST_EXT_SIGNAL = 12'h0C0;
	localparam logic [15:0] RST_PERIOD = 16'h0100;
	localparam logic [15:0] RST_QUEUE_LIMIT = 16'h0040;
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS = 16'hB400;
	localparam logic [3:0] FLOW_BYPASS = 4'hF;

	// Frame presented at enqueue
	typedef struct packed {
		logic [3:0] flow_info;
		logic [7:0] tos;
		logic prio;
		logic mcast;
		logic [5:0] blade;
	} ifc_enq_s;

	// Enqueue verdict, exactly one bit set when valid
	typedef struct packed {
		logic forward;
		logic tail_drop;
		logic random_drop;
	} ifc_dec_s;

	// Congestion report from a remote blade
	typedef struct packed {
		logic prio;
		logic [5:0] blade;
		logic congested;
	} ifc_report_s;

	// Queue counts of the four ports of one target blade
	typedef struct packed {
		logic [5:0] blade;
		logic [3:0][15:0] count;
	} ifc_qupd_s;

	// Buffer allocation permissions
	typedef struct packed {
		logic allow_guided;
		logic allow_user;
		logic allow_new_frame;
	} ifc_alloc_s;

endpackage : ifc_pkg

// *** src/ifc_flow_control.sv ***
// Ingress flow-control assist: buffer cut-offs, statistics, congestion maps and enqueue verdict
`timescale 1ns/10ps

module ifc_flow_control
	import ifc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [8:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	input wire logic buf_take_i,
	input wire logic buf_give_i,
	output ifc_alloc_s alloc_o,
	output logic free_buffer_low_out_o,
	output logic irq_o,
	input wire logic qupd_valid_i,
	input wire ifc_qupd_s qupd_i,
	input wire logic report_valid_i,
	input wire ifc_report_s report_i,
	input wire logic enq_valid_i,
	input wire ifc_enq_s enq_i,
	output logic dec_valid_o,
	output ifc_dec_s dec_o
);

	// Strict less-than against a level, shared by every cut-off
	function automatic logic below(input logic [11:0] cnt, input logic [11:0] lvl);
		below = cnt < lvl;
	endfunction : below

	// Divide by 1, 2, 4 or 8
	function automatic logic [11:0] scale(input logic [11:0] v, input logic [1:0] k);
		scale = v >> k;
	endfunction : scale

	logic [11:0] free_buffer_count_q, guided_stop_level_q, user_stop_level_q;
	logic [11:0] new_frame_stop_level_q, low_buffer_alarm_level_q, free_buffer_average_q;
	logic [11:0] user_stop_release_level_q, new_frame_release_level_q;
	logic [11:0] high_prio_drop_level_q, low_prio_drop_level_q, external_signal_level_q;
	logic [3:0] ctrl_q;
	logic [15:0] sample_period_q, queue_frame_limit_q, lfsr_q, period_cnt_q;
	logic [31:0] arrival_q, rd_data, byte_mask, wr_word;
	logic [2:0] int_status_q, int_status_d, int_mask_q;
	logic [63:0] local_congestion_map_q, remote_congestion_map_p0_q, remote_congestion_map_p1_q;
	logic [7:0] prob_tbl_q [PROB_DEPTH];
	logic user_hold_q, user_hold_d, newf_hold_q, newf_hold_d;
	logic ack_q, access, wr_en, rd_done, prob_sel, take_ok, give_ok, sample_tick;
	logic [1:0] k_sel;
	logic [5:0] prob_wr_idx, probability_index;
	logic [7:0] rnd_val;
	ifc_dec_s dec_d;

	assign access = wb_cyc_i & wb_stb_i;
	// The write lands on the edge where the master sees ack, never earlier
	assign wr_en = access & ack_q & wb_we_i;
	assign rd_done = access & ~ack_q & ~wb_we_i; // Arrival clears as its value is latched
	assign prob_sel = wb_adr_i[PROB_BASE_BIT];
	assign prob_wr_idx = wb_adr_i[7:2];
	assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	// Unselected byte lanes keep the register's present contents
	assign wr_word = (rd_data & ~byte_mask) | (wb_dat_i & byte_mask);
	assign k_sel = ctrl_q[CTRL_K_LSB +: 2];

	// Read multiplexer; unmapped words read as zero
	always_comb begin
		if (prob_sel) begin
			rd_data = {24'h00_0000, prob_tbl_q[prob_wr_idx]};
		end else begin
			unique case ({wb_adr_i[8:2], 2'b00})
				OFF_FREE_COUNT: rd_data = {20'h0_0000, free_buffer_count_q};
				OFF_GUIDED_STOP: rd_data = {20'h0_0000, guided_stop_level_q};
				OFF_USER_STOP: rd_data = {20'h0_0000, user_stop_level_q};
				OFF_NEWF_STOP: rd_data = {20'h0_0000, new_frame_stop_level_q};
				OFF_ALARM: rd_data = {20'h0_0000, low_buffer_alarm_level_q};
				OFF_USER_REL: rd_data = {20'h0_0000, user_stop_release_level_q};
				OFF_NEWF_REL: rd_data = {20'h0_0000, new_frame_release_level_q};
				OFF_HIGH_DROP: rd_data = {20'h0_0000, high_prio_drop_level_q};
				OFF_LOW_DROP: rd_data = {20'h0_0000, low_prio_drop_level_q};
				OFF_EXT_SIGNAL: rd_data = {20'h0_0000, external_signal_level_q};
				OFF_CTRL: rd_data = {28'h000_0000, ctrl_q};
				OFF_PERIOD: rd_data = {16'h0000, sample_period_q};
				OFF_ARRIVAL: rd_data = arrival_q;
				OFF_AVERAGE: rd_data = {20'h0_0000, free_buffer_average_q};
				OFF_INT_STATUS: rd_data = {29'h0000_0000, int_status_q};
				OFF_INT_MASK: rd_data = {29'h0000_0000, int_mask_q};
				OFF_QUEUE_LIMIT: rd_data = {16'h0000, queue_frame_limit_q};
				OFF_STATE: rd_data = {29'h0000_0000, alloc_o};
				OFF_LOCAL_LO: rd_data = local_congestion_map_q[31:0];
				OFF_LOCAL_HI: rd_data = local_congestion_map_q[63:32];
				OFF_REM0_LO: rd_data = remote_congestion_map_p0_q[31:0];
				OFF_REM0_HI: rd_data = remote_congestion_map_p0_q[63:32];
				OFF_REM1_LO: rd_data = remote_congestion_map_p1_q[31:0];
				OFF_REM1_HI: rd_data = remote_congestion_map_p1_q[63:32];
				default: rd_data = 32'h0000_0000;
			endcase
		end
	end

	// Bus handshake: ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			ack_q <= access & ~ack_q;
			wb_dat_o <= (access & ~ack_q) ? rd_data : 32'h0000_0000;
		end
	end
	assign wb_ack_o = ack_q;

	// Software-written levels and configuration
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			guided_stop_level_q <= RST_GUIDED_STOP;
			user_stop_level_q <= RST_USER_STOP;
			new_frame_stop_level_q <= RST_NEWF_STOP;
			low_buffer_alarm_level_q <= RST_ALARM;
			user_stop_release_level_q <= RST_RELEASE;
			new_frame_release_level_q <= RST_RELEASE;
			high_prio_drop_level_q <= RST_HIGH_DROP;
			low_prio_drop_level_q <= RST_LOW_DROP;
			external_signal_level_q <= RST_EXT_SIGNAL;
			ctrl_q <= 4'h0;
			sample_period_q <= RST_PERIOD;
			queue_frame_limit_q <= RST_QUEUE_LIMIT;
			int_mask_q <= 3'h0;
		end else if (wr_en && !prob_sel) begin
			unique case ({wb_adr_i[8:2], 2'b00})
				OFF_GUIDED_STOP: guided_stop_level_q <= wr_word[11:0];
				OFF_USER_STOP: user_stop_level_q <= wr_word[11:0];
				OFF_NEWF_STOP: new_frame_stop_level_q <= wr_word[11:0];
				OFF_ALARM: low_buffer_alarm_level_q <= wr_word[11:0];
				OFF_USER_REL: user_stop_release_level_q <= wr_word[11:0];
				OFF_NEWF_REL: new_frame_release_level_q <= wr_word[11:0];
				OFF_HIGH_DROP: high_prio_drop_level_q <= wr_word[11:0];
				OFF_LOW_DROP: low_prio_drop_level_q <= wr_word[11:0];
				OFF_EXT_SIGNAL: external_signal_level_q <= wr_word[11:0];
				OFF_CTRL: ctrl_q <= wr_word[3:0];
				OFF_PERIOD: sample_period_q <= wr_word[15:0];
				OFF_QUEUE_LIMIT: queue_frame_limit_q <= wr_word[15:0];
				OFF_INT_MASK: int_mask_q <= wr_word[2:0];
				default: ;
			endcase
		end
	end

	// Probability table, filled only by software
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prob_tbl_q <= '{default: 8'hFF};
		end else if (wr_en && prob_sel) begin
			prob_tbl_q[prob_wr_idx] <= wr_word[7:0];
		end
	end

	// Free buffer count; a take at zero or a give at full is ignored
	assign take_ok = buf_take_i & (free_buffer_count_q != 12'h000);
	assign give_ok = buf_give_i & (free_buffer_count_q != FREE_TOTAL);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			free_buffer_count_q <= FREE_TOTAL;
		end else if (take_ok != give_ok) begin
			free_buffer_count_q <= take_ok ? free_buffer_count_q - 12'h001
				: free_buffer_count_q + 12'h001;
		end
	end

	// Cut-off holds; with release enabled they stay set until the count passes the release level
	always_comb begin
		user_hold_d = user_hold_q;
		if (below(free_buffer_count_q, user_stop_level_q)) begin
			user_hold_d = 1'b1;
		end else if (!ctrl_q[CTRL_USER_REL_EN]
				|| free_buffer_count_q > user_stop_release_level_q) begin
			user_hold_d = 1'b0;
		end
		newf_hold_d = newf_hold_q;
		if (below(free_buffer_count_q, new_frame_stop_level_q)) begin
			newf_hold_d = 1'b1;
		end else if (!ctrl_q[CTRL_NEWF_REL_EN]
				|| free_buffer_count_q > new_frame_release_level_q) begin
			newf_hold_d = 1'b0;
		end
	end

	// Allocation permissions; guided stop overrides everything
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			user_hold_q <= 1'b0;
			newf_hold_q <= 1'b0;
			alloc_o <= '{allow_guided: 1'b1, allow_user: 1'b1, allow_new_frame: 1'b1};
		end else begin
			user_hold_q <= user_hold_d;
			newf_hold_q <= newf_hold_d;
			alloc_o.allow_guided <= ~below(free_buffer_count_q, guided_stop_level_q);
			alloc_o.allow_user <= ~below(free_buffer_count_q, guided_stop_level_q)
				& ~user_hold_d;
			alloc_o.allow_new_frame <= ~below(free_buffer_count_q, guided_stop_level_q)
				& ~user_hold_d & ~newf_hold_d;
		end
	end

	// Sticky interrupt causes; a new event beats a same-cycle write-one clear
	always_comb begin
		int_status_d = (wr_en && !prob_sel && {wb_adr_i[8:2], 2'b00} == OFF_INT_STATUS)
			? int_status_q & ~wr_word[2:0] : int_status_q;
		if (below(free_buffer_count_q, user_stop_level_q)) begin
			int_status_d[INT_USER_STOP] = 1'b1;
		end
		if (below(free_buffer_count_q, new_frame_stop_level_q)) begin
			int_status_d[INT_NEWF_STOP] = 1'b1;
		end
		if (below(free_buffer_count_q, low_buffer_alarm_level_q)) begin
			int_status_d[INT_ALARM] = 1'b1;
		end
	end

	// Interrupt line registered from the next status so it is a clean flop output
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_status_q <= 3'h0;
			irq_o <= 1'b0;
		end else begin
			int_status_q <= int_status_d;
			irq_o <= |(int_status_d & int_mask_q);
		end
	end

	// External low-buffer signal for helper devices
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			free_buffer_low_out_o <= 1'b0;
		end else begin
			free_buffer_low_out_o <= below(free_buffer_count_q, external_signal_level_q);
		end
	end

	// Arrival counter; a take during the clearing read counts as the first new arrival
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			arrival_q <= 32'h0000_0000;
		end else if (rd_done && !prob_sel && {wb_adr_i[8:2], 2'b00} == OFF_ARRIVAL) begin
			arrival_q <= {31'h0000_0000, take_ok};
		end else if (take_ok) begin
			arrival_q <= arrival_q + 32'h0000_0001;
		end
	end

	// Sample period timer; a zero period behaves as one cycle
	assign sample_tick = (period_cnt_q + 16'h0001) >= sample_period_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			period_cnt_q <= 16'h0000;
		end else begin
			period_cnt_q <= sample_tick ? 16'h0000 : period_cnt_q + 16'h0001;
		end
	end

	// Moving average in shift form: avg - avg*K + count*K, integer buffers only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			free_buffer_average_q <= FREE_TOTAL;
		end else if (sample_tick) begin
			free_buffer_average_q <= free_buffer_average_q - scale(free_buffer_average_q, k_sel)
				+ scale(free_buffer_count_q, k_sel);
		end
	end

	// Local map: one bit per blade from its four port queue counts
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			local_congestion_map_q <= 64'h0;
		end else if (qupd_valid_i) begin
			local_congestion_map_q[qupd_i.blade] <= (qupd_i.count[0] > queue_frame_limit_q)
				| (qupd_i.count[1] > queue_frame_limit_q) | (qupd_i.count[2] > queue_frame_limit_q)
				| (qupd_i.count[3] > queue_frame_limit_q);
		end
	end

	// Remote maps follow each report for its priority
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			remote_congestion_map_p0_q <= 64'h0;
			remote_congestion_map_p1_q <= 64'h0;
		end else if (report_valid_i && report_i.prio) begin
			remote_congestion_map_p1_q[report_i.blade] <= report_i.congested;
		end else if (report_valid_i) begin
			remote_congestion_map_p0_q[report_i.blade] <= report_i.congested;
		end
	end

	// Random source, stepped every cycle; low byte scaled like a table entry
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lfsr_q <= LFSR_SEED;
		end else begin
			lfsr_q <= lfsr_q[0] ? (lfsr_q >> 1) ^ LFSR_TAPS : lfsr_q >> 1;
		end
	end
	assign rnd_val = lfsr_q[7:0];

	// Table index: class, remote bit (zero for multicast), color
	assign probability_index = {enq_i.tos[7:5],
		enq_i.mcast ? 1'b0 : remote_congestion_map_p1_q[enq_i.blade],
		enq_i.flow_info[1:0]};

	// Enqueue verdict; priority 0 drops are not counted here, software does that
	always_comb begin
		dec_d = '{forward: 1'b1, tail_drop: 1'b0, random_drop: 1'b0};
		if (enq_i.flow_info == FLOW_BYPASS) begin
			dec_d = '{forward: 1'b1, tail_drop: 1'b0, random_drop: 1'b0};
		end else if (!enq_i.prio) begin
			if (below(free_buffer_count_q, high_prio_drop_level_q)
					|| local_congestion_map_q[enq_i.blade]
					|| (!enq_i.mcast && remote_congestion_map_p0_q[enq_i.blade])) begin
				dec_d = '{forward: 1'b0, tail_drop: 1'b1, random_drop: 1'b0};
			end
		end else if (below(free_buffer_count_q, low_prio_drop_level_q)) begin
			dec_d = '{forward: 1'b0, tail_drop: 1'b1, random_drop: 1'b0};
		end else if (prob_tbl_q[probability_index] < rnd_val) begin
			dec_d = '{forward: 1'b0, tail_drop: 1'b0, random_drop: 1'b1};
		end
	end

	// Verdict registered: one cycle after the enqueue request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dec_valid_o <= 1'b0;
			dec_o <= '{forward: 1'b0, tail_drop: 1'b0, random_drop: 1'b0};
		end else begin
			dec_valid_o <= enq_valid_i;
			dec_o <= enq_valid_i ? dec_d : '0;
		end
	end
	// Checks next to the logic they guard
	a_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
	a_guided_stop_all: assert property (@(posedge clk_i) disable iff (rst_i)
		below(free_buffer_count_q, guided_stop_level_q) |=> (alloc_o == 3'b000))
		else $error("allocation allowed below guided stop level");
	a_user_stop_block: assert property (@(posedge clk_i) disable iff (rst_i)
		below(free_buffer_count_q, user_stop_level_q)
		|=> !alloc_o.allow_user && int_status_q[INT_USER_STOP])
		else $error("user traffic not stopped");
	a_newf_release_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		newf_hold_q && ctrl_q[CTRL_NEWF_REL_EN] && free_buffer_count_q <= new_frame_release_level_q
		|=> newf_hold_q && !alloc_o.allow_new_frame)
		else $error("new frame stop released early");
	a_alarm_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		below(free_buffer_count_q, low_buffer_alarm_level_q) |=> int_status_q[INT_ALARM])
		else $error("alarm status not set");
	a_arrival_step: assert property (@(posedge clk_i) disable iff (rst_i)
		take_ok && !rd_done |=> arrival_q == $past(arrival_q) + 32'h0000_0001)
		else $error("arrival counter missed a take");
	a_average_k_one: assert property (@(posedge clk_i) disable iff (rst_i)
		sample_tick && k_sel == 2'b00 |=> free_buffer_average_q == $past(free_buffer_count_q))
		else $error("average with K of one does not follow count");
	a_ext_low_level: assert property (@(posedge clk_i) disable iff (rst_i)
		below(free_buffer_count_q, external_signal_level_q) |=> free_buffer_low_out_o)
		else $error("free buffer low output not raised");
	a_bypass_forward: assert property (@(posedge clk_i) disable iff (rst_i)
		enq_valid_i && enq_i.flow_info == FLOW_BYPASS |=> dec_valid_o && dec_o.forward)
		else $error("bypass frame not forwarded");
	a_low_prio_tail: assert property (@(posedge clk_i) disable iff (rst_i)
		enq_valid_i && enq_i.prio && enq_i.flow_info != FLOW_BYPASS
		&& below(free_buffer_count_q, low_prio_drop_level_q) |=> dec_o.tail_drop)
		else $error("priority 1 frame not tail dropped");
endmodule : ifc_flow_control

// *** bench/ifc_enq_model.sv ***
// Enqueue path model: hands frames to the block and returns its verdicts
`timescale 1ns/10ps
module ifc_enq_model
	import ifc_pkg::*;
(
	input wire logic clk_i,
	output logic enq_valid_o,
	output ifc_enq_s enq_o,
	input wire logic dec_valid_i,
	input wire ifc_dec_s dec_i
);
	int p0_drops = 0;
	// Idle until the first frame
	initial begin
		enq_valid_o = 1'b0;
		enq_o = '0;
	end
	// One-cycle pulse; verdict taken at the edge after the request edge
	task automatic send(input ifc_enq_s f, output ifc_dec_s d);
		@(posedge clk_i);
		enq_valid_o <= 1'b1;
		enq_o <= f;
		@(posedge clk_i);
		enq_valid_o <= 1'b0;
		enq_o <= ~f; // Scrambled so nothing leans on stale fields
		@(posedge clk_i);
		d = dec_valid_i ? dec_i : 3'h0;
		if (d.tail_drop && !f.prio) p0_drops++; // Software keeps this tally
	endtask : send
endmodule : ifc_enq_model

// *** bench/test_ingress_flow_control.sv ***
// Self-checking bench for the ingress flow-control assist
`timescale 1ns/10ps
module test_ingress_flow_control
	import ifc_pkg::*;
;
	logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, buf_take_i, buf_give_i;
	logic free_buffer_low_out_o, irq_o, qupd_valid_i, report_valid_i, enq_valid_i, dec_valid_o;
	logic [8:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [3:0] wb_sel_i;
	ifc_alloc_s alloc_o;
	ifc_qupd_s qupd_i;
	ifc_report_s report_i;
	ifc_enq_s enq_i;
	ifc_dec_s dec_o, d;
	int err_count = 0;
	int n_compared = 0;
	int drops;

	ifc_flow_control uut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
		.wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .buf_take_i, .buf_give_i, .alloc_o,
		.free_buffer_low_out_o, .irq_o, .qupd_valid_i, .qupd_i, .report_valid_i,
		.report_i, .enq_valid_i, .enq_i, .dec_valid_o, .dec_o);
	ifc_enq_model em (.clk_i, .enq_valid_o(enq_valid_i), .enq_o(enq_i),
		.dec_valid_i(dec_valid_o), .dec_i(dec_o));

	// 40 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// Main sequence; every input defined at time zero
	initial begin
		{rst_i, wb_we_i, wb_cyc_i, wb_stb_i, buf_take_i, buf_give_i} = 6'h20;
		{qupd_valid_i, report_valid_i, wb_adr_i, wb_dat_i, wb_sel_i, qupd_i, report_i} = '0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_levels();
		t_enq();
		print_verdict();
	end
	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		print_verdict();
	end

	task automatic print_verdict();
		if (err_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Classic cycle: hold everything until ack is sampled, then release
	task automatic wb(input logic we, input logic [8:0] a, input logic [31:0] wd,
		output logic [31:0] q);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= wd;
		wb_sel_i <= 4'hF;
		// No budget of its own: only the watchdog ends a wait for ack
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb

	task automatic wr(input logic [8:0] a, input logic [31:0] v);
		logic [31:0] q;
		wb(1'b1, a, v, q);
	endtask : wr

	task automatic rd(input string nm, input logic [8:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(nm, e, q);
	endtask : rd

	// Take or return n buffers, then let the levels settle
	task automatic bufs(input logic take, input int n);
		repeat (n) begin
			@(posedge clk_i);
			buf_take_i <= take;
			buf_give_i <= ~take;
		end
		@(posedge clk_i);
		buf_take_i <= 1'b0;
		buf_give_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask : bufs

	task automatic rep(input logic p, input logic [5:0] b);
		@(posedge clk_i);
		report_valid_i <= 1'b1;
		report_i <= {p, b, 1'b1};
		@(posedge clk_i);
		report_valid_i <= 1'b0;
	endtask : rep

	task automatic eq(input string nm, input ifc_enq_s f, input ifc_dec_s e);
		em.send(f, d);
		chk(nm, e, d);
	endtask : eq

	task automatic t_reset();
		rd("free", OFF_FREE_COUNT, FREE_TOTAL);
		rd("guided", OFF_GUIDED_STOP, RST_GUIDED_STOP);
		rd("unmapped", 9'h0FC, 32'h0);
		rd("avg", OFF_AVERAGE, FREE_TOTAL);
		chk("alloc", 3'h7, alloc_o);
	endtask : t_reset

	// Levels set just under full so a handful of takes crosses them
	task automatic t_levels();
		wr(OFF_USER_STOP, 32'h7FE);
		wr(OFF_NEWF_STOP, 32'h7FF);
		wr(OFF_ALARM, 32'h7FD);
		wr(OFF_EXT_SIGNAL, 32'h7FF);
		wr(OFF_INT_MASK, 32'h1);
		wr(OFF_PERIOD, 32'h1);
		bufs(1'b1, 2);
		chk("alloc", 3'h6, alloc_o);
		chk("low", 1'b1, free_buffer_low_out_o);
		chk("irq", 1'b0, irq_o);
		rd("status", OFF_INT_STATUS, 32'h2);
		bufs(1'b1, 1);
		chk("alloc", 3'h4, alloc_o);
		chk("irq", 1'b1, irq_o);
		bufs(1'b1, 1);
		rd("status", OFF_INT_STATUS, 32'h7);
		chk("alloc", 3'h4, alloc_o);
		rd("free", OFF_FREE_COUNT, 32'h7FC);
		rd("avg", OFF_AVERAGE, 32'h7FC);
		rd("arrival", OFF_ARRIVAL, 32'h4);
		rd("arrival", OFF_ARRIVAL, 32'h0);
		wr(OFF_USER_REL, 32'h7FF);
		wr(OFF_CTRL, 32'h1);
		bufs(1'b0, 3);
		chk("alloc", 3'h4, alloc_o);
		bufs(1'b0, 1);
		chk("alloc", 3'h7, alloc_o);
		wr(OFF_INT_STATUS, 32'h7);
		rd("status", OFF_INT_STATUS, 32'h0);
		chk("low", 1'b0, free_buffer_low_out_o);
		wr(OFF_GUIDED_STOP, 32'h801);
		repeat (3) @(posedge clk_i);
		chk("alloc", 3'h0, alloc_o);
		wr(OFF_GUIDED_STOP, 32'h10);
		// K of 1/8: integer average settles three above a count of 7FC
		wr(OFF_CTRL, 32'hC);
		bufs(1'b1, 4);
		rd("avg8", OFF_AVERAGE, 32'h7FF);
	endtask : t_levels

	// Frame layout: flow info, class byte, prio, mcast, blade
	task automatic t_enq();
		wr(OFF_HIGH_DROP, 32'h801);
		eq("p0thr", 20'h00000, 3'h2);
		eq("bypass", 20'hF0000, 3'h4);
		wr(OFF_HIGH_DROP, 32'h20);
		rep(1'b0, 6'h05);
		eq("p0rem", 20'h00005, 3'h2);
		eq("p0mc", 20'h00045, 3'h4);
		@(posedge clk_i);
		qupd_valid_i <= 1'b1;
		qupd_i <= {6'h09, 16'h0, 16'h41, 16'h0, 16'h0};
		@(posedge clk_i);
		qupd_valid_i <= 1'b0;
		eq("p0loc", 20'h00009, 3'h2);
		eq("p0ok", 20'h00006, 3'h4);
		wr(OFF_LOW_DROP, 32'h801);
		eq("p1thr", 20'h00080, 3'h2);
		wr(OFF_LOW_DROP, 32'h60);
		wr(9'h100, 32'h0); // Entry zero almost never passes
		drops = 0;
		repeat (4) begin
			em.send(20'h00080, d);
			drops += (d === 3'h1);
		end
		chk("p1rnd", 1'b1, drops >= 3);
		eq("p1col", 20'h10080, 3'h4);
		eq("p1cls", 20'h02080, 3'h4);
		rep(1'b1, 6'h07);
		eq("p1rem", 20'h00087, 3'h4);
		chk("p0drops", 32'h3, em.p0_drops);
	endtask : t_enq
endmodule : test_ingress_flow_control
